// [src/ftd_pkg.sv]
// Package of constants for the four-channel two-cycle transfer controller
`default_nettype none
package ftd_pkg;
  // Register byte offsets per channel block (channel n at n * CH_STRIDE)
  localparam logic [11:0] CH_STRIDE = 12'h020;
  localparam logic [4:0] OFS_SRC = 5'h00;
  localparam logic [4:0] OFS_DST = 5'h04;
  localparam logic [4:0] OFS_CNT = 5'h08;
  localparam logic [4:0] OFS_CFG = 5'h0C;
  localparam logic [4:0] OFS_CTL = 5'h10;
  localparam logic [4:0] OFS_TRG = 5'h14;
  // Global register offset
  localparam logic [11:0] OFS_WAIT = 12'h100;
  // Control register fields
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_TC_BIT = 1;
  localparam int CTL_STG_BIT = 2;
  localparam int CTL_PEND_BIT = 3;
  // Config register fields
  localparam int CFG_SIZE_BIT = 0;
  localparam int CFG_SSP_LSB = 4;
  localparam int CFG_DSP_LSB = 6;
  localparam int CFG_SINC_BIT = 8;
  localparam int CFG_DINC_BIT = 9;
  // Trigger select field width
  localparam int TRG_W = 6;
  // Reset values
  localparam logic [7:0] WAIT_RST = 8'h77;
  localparam logic [15:0] CNT_RST = 16'h0000;
  // Timing counts in clocks
  localparam logic [3:0] RESP_CLKS = 4'h4;
  localparam logic [3:0] RAM_CLKS = 4'h2;
  localparam logic [3:0] PER_CLKS = 4'h3;
  localparam logic [3:0] IDLE_CLKS = 4'h1;
  // Memory spaces
  typedef enum logic [1:0] {FTD_SP_PER, FTD_SP_RAM, FTD_SP_EXT8, FTD_SP_EXT16} ftd_space_t;
endpackage : ftd_pkg
`default_nettype wire

// [src/ftd_core.sv]
// Four-channel fixed-priority two-cycle transfer controller with APB registers
// Function
// - Each unit is read then write
// - Source address on read, destination on write
// - At least one idle clock between read, write
// - 32-to-16 bus uses one 16-bit read/write
// - 16-bit onto 8-bit: one read, two writes
// - 8-bit into 16-bit: two reads, one write
// - Peripheral 16, RAM 32, external 8/16 bits
// - Fixed priority channel 0 highest, rechecked
// - Request response takes at least four clocks
// - RAM two clocks, peripheral three plus wait
// - Soft trigger starts one unit if enabled
// - Selected peripheral irq starts a unit
// - Terminal count clears enable, sets flag, pulses
// - Both triggers together: only one accepted
// - Requests while pending or active are discarded
// - Drop own channel, grant highest, keep others
// - Bus hold suspends transfers until released
// - No terminal count pin off chip
// - Reading control register clears terminal flag
// - Bus released after every transfer unit
`default_nettype none
module ftd_core
  import ftd_pkg::*;
#(
  parameter int NCH = 4,
  parameter int NSRC = 64
)(
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Peripheral interrupt sources (same clock)
  input wire logic [NSRC-1:0] i_periph_irq,
  // Bus hold from outside
  input wire logic i_bus_hold,
  // Memory master port
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [1:0] o_mem_space,
  output logic [31:0] o_mem_addr,
  output logic [1:0] o_mem_size,
  output logic [15:0] o_mem_wdata,
  output logic o_mem_wdata_oe,
  input wire logic i_mem_ack,
  input wire logic [15:0] i_mem_rdata,
  output logic o_bus_owned,
  output logic [NCH-1:0] o_transfer_end_irq
);
  typedef enum {FTD_IDLE, FTD_RESP, FTD_READ, FTD_GAP, FTD_WRITE} ftd_state_t;

  // Synchronised bus hold
  logic hold_s1_reg;
  logic hold_reg;
  always_ff @(posedge i_clk_sys)
  begin
    hold_s1_reg <= i_bus_hold;
    hold_reg <= hold_s1_reg;
  end

  // Per-channel registers, then wait register and sequencer state
  logic [31:0] src_reg [NCH];
  logic [31:0] dst_reg [NCH];
  logic [15:0] cnt_reg [NCH];
  logic [9:0] cfg_reg [NCH];
  logic [TRG_W-1:0] trg_reg [NCH];
  logic [NCH-1:0] en_reg;
  logic [NCH-1:0] tc_reg;
  logic [NCH-1:0] pend_reg;
  logic [7:0] wait_reg;
  ftd_state_t state_reg;
  logic [1:0] ch_reg;
  logic [3:0] tmr_reg;
  logic phase_reg;
  logic [15:0] data_reg;
  logic done_pulse;

  // APB decode
  logic wr_acc;
  logic rd_acc;
  logic [2:0] sel_ch;
  logic [4:0] sel_ofs;
  logic in_ch;
  assign wr_acc = i_psel && i_penable && i_pwrite;
  assign rd_acc = i_psel && i_penable && !i_pwrite;
  assign sel_ch = i_paddr[7:5];
  assign sel_ofs = i_paddr[4:0];
  assign in_ch = (i_paddr[11:8] == 4'h0) && (int'(sel_ch) < NCH);
  assign o_pready = 1'b1;

  // Unmapped accesses return an error
  always_comb
  begin
    o_pslverr = 1'b0;
    if (i_psel && i_penable)
    begin
      if (i_paddr == OFS_WAIT)
        o_pslverr = 1'b0;
      else if (!in_ch || sel_ofs > OFS_TRG || sel_ofs[1:0] != 2'b00)
        o_pslverr = 1'b1;
    end
  end

  // Read data register
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
      o_prdata <= 32'h0000_0000;
    else if (i_psel && !i_penable && !i_pwrite)
    begin
      o_prdata <= 32'h0000_0000;
      if (i_paddr == OFS_WAIT)
        o_prdata <= {24'h000000, wait_reg};
      else if (in_ch)
        unique case (sel_ofs)
          OFS_SRC: o_prdata <= src_reg[sel_ch[1:0]];
          OFS_DST: o_prdata <= dst_reg[sel_ch[1:0]];
          OFS_CNT: o_prdata <= {16'h0000, cnt_reg[sel_ch[1:0]]};
          OFS_CFG: o_prdata <= {22'h0, cfg_reg[sel_ch[1:0]]};
          OFS_CTL: o_prdata <= {28'h0000000, pend_reg[sel_ch[1:0]], 1'b0,
                                tc_reg[sel_ch[1:0]], en_reg[sel_ch[1:0]]};
          OFS_TRG: o_prdata <= {26'h0, trg_reg[sel_ch[1:0]]};
          default: o_prdata <= 32'h0000_0000;
        endcase
    end
  end

  // Wait control register
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
      wait_reg <= WAIT_RST;
    else if (wr_acc && i_paddr == OFS_WAIT)
      wait_reg <= i_pwdata[7:0];
  end

  // Per-channel request, enable and terminal flag logic
  logic [NCH-1:0] busy_ch;
  logic [NCH-1:0] grant_take;
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      logic hit;
      logic soft_trig;
      logic hw_trig;
      logic is_last;
      assign hit = in_ch && sel_ch[1:0] == 2'(g);
      assign soft_trig = wr_acc && hit && sel_ofs == OFS_CTL && i_pwdata[CTL_STG_BIT];
      assign hw_trig = trg_reg[g] != '0 && i_periph_irq[trg_reg[g]];
      assign busy_ch[g] = (state_reg != FTD_IDLE) && ch_reg == 2'(g);
      assign is_last = done_pulse && ch_reg == 2'(g) && cnt_reg[g] == 16'h0001;

      // Pending request; either trigger counts once
      always_ff @(posedge i_clk_sys)
      begin
        if (i_srst)
          pend_reg[g] <= 1'b0;
        else if (grant_take[g])
          pend_reg[g] <= 1'b0;
        else if (en_reg[g] && !tc_reg[g] && !pend_reg[g] && !busy_ch[g] && (soft_trig || hw_trig))
          pend_reg[g] <= 1'b1;
      end

      // Enable bit, cleared by terminal count
      always_ff @(posedge i_clk_sys)
      begin
        if (i_srst)
          en_reg[g] <= 1'b0;
        else if (is_last)
          en_reg[g] <= 1'b0;
        else if (wr_acc && hit && sel_ofs == OFS_CTL)
          en_reg[g] <= i_pwdata[CTL_EN_BIT];
      end

      // Terminal flag: set wins over clear on read
      always_ff @(posedge i_clk_sys)
      begin
        if (i_srst)
          tc_reg[g] <= 1'b0;
        else if (is_last)
          tc_reg[g] <= 1'b1;
        else if (rd_acc && hit && sel_ofs == OFS_CTL)
          tc_reg[g] <= 1'b0;
      end

      // End interrupt pulse; no count pin leaves the chip
      always_ff @(posedge i_clk_sys)
      begin
        if (i_srst)
          o_transfer_end_irq[g] <= 1'b0;
        else
          o_transfer_end_irq[g] <= is_last;
      end

      // Address, count, config and trigger select registers
      always_ff @(posedge i_clk_sys)
      begin
        if (i_srst)
        begin
          src_reg[g] <= 32'h0000_0000;
          dst_reg[g] <= 32'h0000_0000;
          cnt_reg[g] <= CNT_RST;
          cfg_reg[g] <= 10'h000;
          trg_reg[g] <= '0;
        end
        else
        begin
          if (done_pulse && ch_reg == 2'(g))
          begin
            cnt_reg[g] <= cnt_reg[g] - 16'h0001;
            if (cfg_reg[g][CFG_SINC_BIT])
              src_reg[g] <= src_reg[g] + (cfg_reg[g][CFG_SIZE_BIT] ? 32'h2 : 32'h1);
            if (cfg_reg[g][CFG_DINC_BIT])
              dst_reg[g] <= dst_reg[g] + (cfg_reg[g][CFG_SIZE_BIT] ? 32'h2 : 32'h1);
          end
          else if (wr_acc && hit)
            unique case (sel_ofs)
              OFS_SRC: src_reg[g] <= i_pwdata;
              OFS_DST: dst_reg[g] <= i_pwdata;
              OFS_CNT: cnt_reg[g] <= i_pwdata[15:0];
              OFS_CFG: cfg_reg[g] <= i_pwdata[9:0];
              OFS_TRG: trg_reg[g] <= i_pwdata[TRG_W-1:0];
              default: ;
            endcase
        end
      end
    end
  endgenerate

  // Fixed priority pick among pending channels
  logic [1:0] pick;
  logic any_pend;
  always_comb
  begin
    pick = 2'd0;
    any_pend = 1'b0;
    for (int i = NCH - 1; i >= 0; i--)
      if (pend_reg[i])
      begin
        pick = 2'(i);
        any_pend = 1'b1;
      end
  end

  assign grant_take = (state_reg == FTD_IDLE && any_pend && !hold_reg)
                      ? (NCH'(1) << pick) : '0;

  // Active channel's widths
  logic [1:0] s_sp;
  logic [1:0] d_sp;
  logic half;
  logic s_byte;
  logic d_byte;
  assign s_sp = cfg_reg[ch_reg][CFG_SSP_LSB +: 2];
  assign d_sp = cfg_reg[ch_reg][CFG_DSP_LSB +: 2];
  assign half = cfg_reg[ch_reg][CFG_SIZE_BIT];
  // External 8-bit space is the only byte-wide bus
  assign s_byte = half && s_sp == FTD_SP_EXT8;
  assign d_byte = half && d_sp == FTD_SP_EXT8;

  // Access length for a space: RAM two, peripheral three plus wait
  function automatic logic [3:0] acc_len(input logic [1:0] sp, input logic [7:0] w);
    logic [3:0] n;
    n = 4'h1;
    if (sp == FTD_SP_RAM)
      n = RAM_CLKS;
    else if (sp == FTD_SP_PER)
      n = PER_CLKS + w[3:0];
    return n;
  endfunction : acc_len

  // Transfer sequencer
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      state_reg <= FTD_IDLE;
      ch_reg <= 2'd0;
      tmr_reg <= 4'h0;
      phase_reg <= 1'b0;
      data_reg <= 16'h0000;
    end
    else
      unique case (state_reg)
        FTD_IDLE:
          if (grant_take != '0)
          begin
            ch_reg <= pick;
            tmr_reg <= RESP_CLKS - 4'h1;
            phase_reg <= 1'b0;
            state_reg <= FTD_RESP;
          end
        FTD_RESP:
          if (tmr_reg != 4'h0)
            tmr_reg <= tmr_reg - 4'h1;
          else if (!hold_reg)
          begin
            tmr_reg <= acc_len(s_sp, wait_reg) - 4'h1;
            state_reg <= FTD_READ;
          end
        FTD_READ:
          if (tmr_reg != 4'h0)
            tmr_reg <= tmr_reg - 4'h1;
          else if (i_mem_ack)
          begin
            if (s_byte)
              data_reg[phase_reg*8 +: 8] <= i_mem_rdata[7:0];
            else
              data_reg <= i_mem_rdata;
            if (s_byte && !phase_reg)
            begin
              phase_reg <= 1'b1;
              tmr_reg <= acc_len(s_sp, wait_reg) - 4'h1;
            end
            else
            begin
              phase_reg <= 1'b0;
              tmr_reg <= IDLE_CLKS - 4'h1;
              state_reg <= FTD_GAP;
            end
          end
        FTD_GAP:
          if (!hold_reg)
          begin
            tmr_reg <= acc_len(d_sp, wait_reg) - 4'h1;
            state_reg <= FTD_WRITE;
          end
        FTD_WRITE:
          if (tmr_reg != 4'h0)
            tmr_reg <= tmr_reg - 4'h1;
          else if (i_mem_ack)
          begin
            if (d_byte && !phase_reg)
            begin
              phase_reg <= 1'b1;
              tmr_reg <= acc_len(d_sp, wait_reg) - 4'h1;
            end
            else
              state_reg <= FTD_IDLE;
          end
      endcase
  end

  assign done_pulse = state_reg == FTD_WRITE && tmr_reg == 4'h0 && i_mem_ack
                      && !(d_byte && !phase_reg);

  // Memory port: source on read, destination on write
  always_comb
  begin
    o_mem_req = (state_reg == FTD_READ || state_reg == FTD_WRITE) && tmr_reg == 4'h0;
    o_mem_we = state_reg == FTD_WRITE;
    o_mem_space = o_mem_we ? d_sp : s_sp;
    o_mem_addr = o_mem_we ? dst_reg[ch_reg] : src_reg[ch_reg];
    if (half)
      o_mem_addr[0] = 1'b0;
    if ((o_mem_we ? d_byte : s_byte))
      o_mem_addr[0] = phase_reg;
    // Size code: 0 byte, 1 halfword; upper 16 bits never driven
    o_mem_size = (half && !(o_mem_we ? d_byte : s_byte)) ? 2'd1 : 2'd0;
    o_mem_wdata = (d_byte && phase_reg) ? {8'h00, data_reg[15:8]} : data_reg;
    o_mem_wdata_oe = o_mem_req && o_mem_we;
    o_bus_owned = state_reg != FTD_IDLE && state_reg != FTD_RESP;
  end
endmodule : ftd_core
`default_nettype wire

// [testbench/ftd_mem_model.sv]
// Memory partner model: internal RAM, peripheral registers, external memory
`default_nettype none
module ftd_mem_model
  import ftd_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_slow,
  input wire logic i_mem_req,
  input wire logic [1:0] i_mem_space,
  input wire logic [31:0] i_mem_addr,
  output logic o_mem_ack,
  output logic [15:0] o_mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_reg = 2'h0;
  logic [15:0] last_reg = 16'h0000;
  // External memory may stretch an access by three clocks
  assign o_mem_ack = i_mem_req && (i_mem_space < FTD_SP_EXT8 || !i_slow || &wait_reg);
  // Data follows the address; an idle bus shows the inverse of the last value
  assign o_mem_rdata = o_mem_ack ? (i_mem_addr[15:0] ^ 16'hA5C3) : ~last_reg;
  // Wait counter and last driven value
  always_ff @(posedge i_clk_sys)
  begin
    wait_reg <= (i_mem_req && !o_mem_ack) ? wait_reg + 2'h1 : 2'h0;
    if (o_mem_ack)
      last_reg <= o_mem_rdata;
  end
endmodule : ftd_mem_model
`default_nettype wire

// [testbench/ftd_core_monitor.sv]
// Checker on the memory port of the transfer controller
`default_nettype none
module ftd_monitor
  import ftd_pkg::*;
#(
  parameter int NCH = 4,
  parameter int NSRC = 64
)(
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic [NSRC-1:0] i_periph_irq,
  input wire logic i_bus_hold,
  input wire logic o_mem_req,
  input wire logic o_mem_we,
  input wire logic [1:0] o_mem_space,
  input wire logic [31:0] o_mem_addr,
  input wire logic o_mem_wdata_oe,
  input wire logic i_mem_ack,
  input wire logic o_bus_owned,
  input wire logic [NCH-1:0] o_transfer_end_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] hold_cnt;
  logic [3:0] idle_cnt;
  logic wr_ack;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);
  assign wr_ack = o_mem_req && o_mem_we && i_mem_ack;
  // Saturating counts of hold cycles and of quiet bus cycles
  always_ff @(posedge i_clk_sys)
  begin
    hold_cnt <= (i_srst || !i_bus_hold) ? 5'h00 : hold_cnt + {4'h0, ~&hold_cnt};
    idle_cnt <= (i_srst || o_bus_owned || o_mem_req) ? 4'h0 : idle_cnt + {3'h0, ~&idle_cnt};
  end
  sequence s_rd_done;
    o_mem_req && i_mem_ack && !o_mem_we;
  endsequence
  sequence s_gap;
    s_rd_done ##1 !o_mem_req;
  endsequence
  a_gap_after_read: assert property (
    s_rd_done ##0 o_mem_space != FTD_SP_EXT8 |=> !o_mem_req)
    else $error("no idle clock after read");
  a_write_follows: assert property (s_gap |-> ##[1:60] (o_mem_req && o_mem_we))
    else $error("read not followed by write");
  a_req_held: assert property (
    o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
    else $error("access changed before ack");
  a_oe_on_write: assert property (o_mem_req && o_mem_we |-> o_mem_wdata_oe)
    else $error("write data not driven");
  a_oe_off_read: assert property (o_mem_req && !o_mem_we |-> !o_mem_wdata_oe)
    else $error("data driven during read");
  a_end_pulse: assert property (
    |o_transfer_end_irq |-> $onehot(o_transfer_end_irq) ##1 !(|o_transfer_end_irq))
    else $error("end pulse not single");
  a_end_after_wr: assert property (
    $rose(|o_transfer_end_irq) |-> $past(wr_ack) || $past(wr_ack, 2))
    else $error("end pulse without final write");
  a_hold_stops: assert property (hold_cnt > 5'h18 |-> !$rose(o_mem_req))
    else $error("access started under bus hold");
  a_resp_min: assert property (
    idle_cnt == 4'hF && $rose(|i_periph_irq) |-> !o_mem_req [*5])
    else $error("response faster than four clocks");
  // RAM write strobes on its second clock, peripheral write not before its third
  a_ram_two_clk: assert property (
    s_gap ##1 (o_mem_we && !o_mem_req && o_mem_space == FTD_SP_RAM) |=> o_mem_req)
    else $error("internal RAM write not two clocks");
  a_per_three_clk: assert property (
    s_gap ##1 (o_mem_we && !o_mem_req && o_mem_space == FTD_SP_PER) |=> !o_mem_req)
    else $error("peripheral write shorter than three clocks");
endmodule : ftd_monitor
bind ftd_core ftd_monitor #(.NCH(NCH), .NSRC(NSRC)) i_mon (.i_clk_sys(i_clk_sys),
  .i_srst(i_srst), .i_periph_irq(i_periph_irq), .i_bus_hold(i_bus_hold),
  .o_mem_req(o_mem_req), .o_mem_we(o_mem_we), .o_mem_space(o_mem_space),
  .o_mem_addr(o_mem_addr), .o_mem_wdata_oe(o_mem_wdata_oe), .i_mem_ack(i_mem_ack),
  .o_bus_owned(o_bus_owned), .o_transfer_end_irq(o_transfer_end_irq));
`default_nettype wire

// [testbench/ftd_core_bench.sv]
// Self-checking bench for the four-channel transfer controller
`default_nettype none
module ftd_core_bench
  import ftd_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] W_CFG [4] = '{32'h11, 32'h91, 32'h61, 32'hC1};
  localparam int W_RD [4] = '{1, 1, 2, 1};
  localparam int W_WR [4] = '{1, 2, 1, 1};
  logic clk, srst, psel, pen, pwr, hold, slow, pready, req, we, ack, perr, perr_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, maddr, q;
  logic [63:0] irq;
  logic [1:0] space, size, wsz;
  logic [15:0] wdata, rdata;
  logic [3:0] endi, end_v;
  logic [31:0] wq[$], wd[$], rq[$];
  int num_errors, tests_run, end_n;
  ftd_core i_dut (.i_clk_sys(clk), .i_srst(srst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(perr), .i_periph_irq(irq), .i_bus_hold(hold),
    .o_mem_req(req), .o_mem_we(we), .o_mem_space(space), .o_mem_addr(maddr),
    .o_mem_size(size), .o_mem_wdata(wdata), .o_mem_wdata_oe(), .i_mem_ack(ack),
    .i_mem_rdata(rdata), .o_bus_owned(), .o_transfer_end_irq(endi));
  ftd_mem_model i_mem (.i_clk_sys(clk), .i_slow(slow), .i_mem_req(req),
    .i_mem_space(space), .i_mem_addr(maddr), .o_mem_ack(ack), .o_mem_rdata(rdata));
  // Clock of 25 ns
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Logs finished accesses and end pulses
  always @(posedge clk)
  begin
    if (req && ack && we)
    begin
      wq.push_back(maddr);
      wd.push_back({16'h0000, wdata});
      wsz = size;
    end
    if (req && ack && !we)
      rq.push_back(maddr);
    if (|endi)
    begin
      end_n++;
      end_v = endi;
    end
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    perr_q = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic prog(input logic [11:0] b, input logic [31:0] s, input logic [31:0] d,
    input logic [31:0] n, input logic [31:0] c, input logic [31:0] t);
    wr(b + OFS_SRC, s);
    wr(b + OFS_DST, d);
    wr(b + OFS_CNT, n);
    wr(b + OFS_CFG, c);
    wr(b + OFS_TRG, t);
    wr(b + OFS_CTL, 32'h1);
  endtask : prog
  task automatic wait_wr(input int n);
    int k;
    k = 0;
    while (wq.size() < n && k < 400)
    begin
      @(posedge clk);
      k++;
    end
    chk(wq.size(), n);
  endtask : wait_wr
  // Watchdog
  initial
  begin
    repeat (8000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
  // Test sequence
  initial
  begin
    {srst, psel, pen, pwr, hold, slow} = 6'h20;
    paddr = 12'h000;
    pwdata = 32'h0;
    irq = 64'h0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(OFS_WAIT, 32'h77);
    chk(perr_q, 32'h0);
    rd(12'h0FC, 32'h0);
    chk(perr_q, 32'h1);
    wr(OFS_WAIT, 32'h0);
    $display("test reset done");
    prog(12'h000, 32'h1000, 32'h2000, 32'h2, 32'h351, 32'h0);
    wr(OFS_CTL, 32'h5);
    wait_wr(1);
    chk(rq[0], 32'h1000);
    chk(wq[0], 32'h2000);
    chk(wd[0], 32'hB5C3);
    rd(OFS_CNT, 32'h1);
    wr(OFS_CTL, 32'h5);
    wait_wr(2);
    chk(wq[1], 32'h2002);
    repeat (4) @(posedge clk);
    chk(end_n, 1);
    chk(end_v, 32'h1);
    rd(OFS_CTL, 32'h2);
    rd(OFS_CTL, 32'h0);
    $display("test soft trigger done");
    slow <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      wq.delete();
      rq.delete();
      prog(CH_STRIDE, 32'h1000, 32'h3000, 32'h1, W_CFG[i], 32'h0);
      wr(CH_STRIDE + OFS_CTL, 32'h5);
      wait_wr(W_WR[i]);
      repeat (20) @(posedge clk);
      chk(rq.size(), W_RD[i]);
      chk(wq.size(), W_WR[i]);
      chk(wsz, (W_WR[i] == 2) ? 32'h0 : 32'h1);
      rd(CH_STRIDE + OFS_CTL, 32'h2);
    end
    $display("test bus widths done");
    wq.delete();
    prog(12'h000, 32'h1000, 32'h4000, 32'h2, 32'h351, 32'h1);
    prog(CH_STRIDE * 12'h2, 32'h1000, 32'h4200, 32'h1, 32'h351, 32'h2);
    prog(CH_STRIDE * 12'h3, 32'h1000, 32'h4300, 32'h1, 32'h351, 32'h3);
    repeat (20) @(posedge clk);
    irq <= 64'hE;
    @(posedge clk);
    irq <= 64'h0;
    repeat (6) @(posedge clk);
    irq <= 64'h2;
    @(posedge clk);
    irq <= 64'h0;
    wait_wr(3);
    chk(wq[0], 32'h4000);
    chk(wq[1], 32'h4200);
    chk(wq[2], 32'h4300);
    repeat (40) @(posedge clk);
    chk(wq.size(), 3);
    rd(OFS_CNT, 32'h1);
    $display("test priority done");
    wq.delete();
    hold <= 1'b1;
    prog(CH_STRIDE, 32'h1000, 32'h5000, 32'h1, 32'h351, 32'h0);
    wr(CH_STRIDE + OFS_CTL, 32'h5);
    repeat (40) @(posedge clk);
    chk(wq.size(), 0);
    hold <= 1'b0;
    wait_wr(1);
    $display("test bus hold done");
    tally_and_finish();
  end
endmodule : ftd_core_bench
`default_nettype wire
